// *** logic/aid_pkg.sv ***
// Shared constants and types of the ALU instruction datapath.
// Assumes one clock domain; imported by the datapath and its ALU core.
package aid_pkg;

    // ---------------------------------------------------------------
    // Widths and register map
    // ---------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int SEL_W = 5;
    localparam int LSEL_W = 4;
    localparam int PHYS_W = 6;
    localparam int SHAMT_W = 3;
    localparam int PHYS_REGS = 44;
    localparam int IDX_COUNT = 4;
    localparam int IDX_SEL_W = 2;
    localparam logic [SEL_W-1:0] BANKED_REGS = 5'h0C;
    localparam logic [SEL_W-1:0] LIMITED_REGS = 5'h10;
    localparam logic [PHYS_W-1:0] ALT_BANK_BASE = 6'h10;
    localparam logic [PHYS_W-1:0] UPPER_OFFSET = 6'h0C;
    localparam logic [SEL_W-1:0] ACC_REG = 5'h00;

    // ---------------------------------------------------------------
    // Reset values and flag positions
    // ---------------------------------------------------------------
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] IDX_STEP = 16'h0001;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 2;
    localparam int FLAG_N = 3;

    // ---------------------------------------------------------------
    // Operations and index modes
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        nop_op,
        add_imm_op,
        sum_with_acc_op,
        sum_with_acc_carry_op,
        sub_imm_op,
        diff_with_acc_op,
        diff_with_acc_borrow_op,
        and_imm_op,
        mask_with_acc_op,
        or_imm_op,
        merge_with_acc_op,
        xor_imm_op,
        toggle_with_acc_op,
        invert_register_op,
        shift_left_op,
        shift_right_op,
        rotate_op,
        compare_immediate_op,
        bit_test_op
    } aid_op_e;

    typedef enum logic [1:0] {
        idx_keep,
        idx_post_dec,
        idx_post_inc,
        idx_pre_inc
    } aid_idx_mode_e;

endpackage

// *** logic/aid_alu_if.sv ***
// Carrier between the datapath and its ALU core.
// Assumes aid_pkg is compiled first; purely combinational signals.
`timescale 1ns/1ps
interface aid_alu_if;
    import aid_pkg::*;
    aid_op_e op;
    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic cin;
    logic [SHAMT_W-1:0] shamt;
    logic [DATA_W-1:0] res;
    logic [3:0] flags;
    logic [3:0] flag_upd;
    logic keeps_result;

    modport core (
        input op, opa, opb, cin, shamt,
        output res, flags, flag_upd, keeps_result
    );
    modport user (
        output op, opa, opb, cin, shamt,
        input res, flags, flag_upd, keeps_result
    );
endinterface

// *** logic/aid_alu.sv ***
// Combinational ALU core: add/sub, logic, barrel shift, flags.
// Assumes operands already selected by the datapath.
`timescale 1ns/1ps
module aid_alu (
    aid_alu_if.core alu // Operands in, result and flags out
);
    import aid_pkg::*;

    logic [DATA_W-1:0] bx;
    logic ci;
    logic [DATA_W:0] sum;
    logic [2*DATA_W-1:0] wide;

    // ---------------------------------------------------------------
    // Adder: subtract as a plus inverted b; carry flag means borrow
    // ---------------------------------------------------------------
    always_comb begin
        bx = alu.opb;
        ci = 1'b0;
        case (alu.op)
            sum_with_acc_carry_op: ci = alu.cin; // [RULE4]
            sub_imm_op, diff_with_acc_op, compare_immediate_op: begin
                bx = ~alu.opb; // [RULE5] [RULE6] [RULE15]
                ci = 1'b1;
            end
            diff_with_acc_borrow_op: begin
                bx = ~alu.opb; // [RULE7]
                ci = ~alu.cin;
            end
            default: ;
        endcase
        sum = {1'b0, alu.opa} + {1'b0, bx} + {8'h00, ci}; // [RULE1]
    end

    always_comb begin
        wide = 16'h0000;
        alu.res = sum[DATA_W-1:0];
        alu.flags = 4'h0;
        alu.flag_upd = 4'h0;
        alu.keeps_result = 1'b1;
        alu.flags[FLAG_C] = sum[DATA_W];
        alu.flags[FLAG_V] = (alu.opa[7] == bx[7]) && (sum[7] != alu.opa[7]); // [RULE20]
        case (alu.op)
            add_imm_op, sum_with_acc_op, sum_with_acc_carry_op: begin
                alu.flag_upd = 4'hF; // [RULE20]
            end
            sub_imm_op, diff_with_acc_op, diff_with_acc_borrow_op: begin
                alu.flags[FLAG_C] = ~sum[DATA_W];
                alu.flag_upd = 4'hF;
            end
            compare_immediate_op: begin
                alu.flags[FLAG_C] = ~sum[DATA_W];
                alu.flag_upd = 4'hF;
                alu.keeps_result = 1'b0; // [RULE17]
            end
            and_imm_op, mask_with_acc_op: alu.res = alu.opa & alu.opb; // [RULE11]
            or_imm_op, merge_with_acc_op: alu.res = alu.opa | alu.opb; // [RULE11]
            xor_imm_op, toggle_with_acc_op: alu.res = alu.opa ^ alu.opb; // [RULE11]
            invert_register_op: alu.res = ~alu.opa; // [RULE13]
            bit_test_op: begin
                alu.res = alu.opa & alu.opb; // [RULE16]
                alu.keeps_result = 1'b0; // [RULE17]
            end
            shift_left_op: begin
                wide = {8'h00, alu.opa} << alu.shamt; // [RULE14]
                alu.res = wide[7:0];
                alu.flags[FLAG_C] = wide[8];
            end
            shift_right_op: begin
                wide = {alu.opa, 8'h00} >> alu.shamt; // [RULE14]
                alu.res = wide[15:8];
                alu.flags[FLAG_C] = wide[7];
            end
            rotate_op: begin
                wide = {alu.opa, alu.opa} << alu.shamt; // [RULE14]
                alu.res = wide[15:8];
                alu.flags[FLAG_C] = wide[8];
            end
            default: alu.keeps_result = 1'b0;
        endcase
        if (alu.op inside {shift_left_op, shift_right_op, rotate_op}) begin
            alu.flag_upd = 4'b1011;
        end else if (alu.flag_upd == 4'h0 && alu.op != nop_op) begin
            alu.flag_upd = 4'b1001;
        end
        alu.flags[FLAG_Z] = (alu.res == 8'h00);
        alu.flags[FLAG_N] = alu.res[7];
    end

endmodule

// *** logic/aid_datapath.sv ***
// Top of the ALU instruction datapath: register file, index registers,
// condition flags and indexed data-memory write port around aid_alu.
// Assumes a decoder presents one instruction per cycle on instr_*.
//
// Overview of operation
// RULE1: Add and subtract work on 8-bit two's-complement operands, 8-bit result.
// RULE2: Immediate add adds 8-bit value to limited register, writes it back there.
// RULE3: Accumulator add sums source and accumulator into register or indexed memory.
// RULE4: Add-with-carry sums source, accumulator and carry into register or memory.
// RULE5: Immediate subtract takes value from limited register, stores there.
// RULE6: Accumulator subtract: source minus accumulator into register or memory.
// RULE7: Subtract-with-borrow: source minus accumulator minus carry into register or memory.
// RULE8: Accumulator arithmetic accepts separate destination, leaving sources intact.
// RULE9: Implied accumulator comes from the currently selected register bank.
// RULE10: Immediate arithmetic uses one register as both source and destination.
// RULE11: AND, OR, XOR are bitwise on 8 bits with immediate or accumulator.
// RULE12: Accumulator logic may write another register or indexed memory.
// RULE13: Complement inverts any full-range register in place.
// RULE14: Shift left, shift right and rotate apply to any 8-bit register.
// RULE15: Compare subtracts an immediate from a register to set flags.
// RULE16: Bit test ANDs a register with an immediate mask.
// RULE17: Compare and bit test write nothing but the flags.
// RULE18: Limited fields reach lowest 28 locations; full fields all visible registers.
// RULE19: Indexed destination may keep, pre-increment, post-increment or post-decrement index.
// RULE20: Arithmetic updates zero, carry, overflow, negative; overflow is signed.
`timescale 1ns/1ps
module aid_datapath (
    input wire logic sys_clk, // Processor clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic instr_valid, // Execute instr_* this cycle
    input aid_pkg::aid_op_e instr_op, // Operation
    input wire logic [aid_pkg::SEL_W-1:0] source_reg_operand, // Source register
    input wire logic [aid_pkg::SEL_W-1:0] dest_reg_sel, // Destination register
    input wire logic [aid_pkg::DATA_W-1:0] imm_value, // Immediate / shift count
    input wire logic dst_is_mem, // Accumulator forms: write data memory
    input wire logic [aid_pkg::IDX_SEL_W-1:0] idx_sel, // Index register choice
    input aid_pkg::aid_idx_mode_e idx_mode, // Index update mode
    input wire logic bank_sel, // Active alternate bank for R0-R11
    input wire logic ld_valid, // Register load strobe
    input wire logic [aid_pkg::SEL_W-1:0] ld_sel, // Register load target
    input wire logic [aid_pkg::DATA_W-1:0] ld_data, // Register load data
    input wire logic idx_ld_valid, // Index load strobe
    input wire logic [aid_pkg::IDX_SEL_W-1:0] idx_ld_sel, // Index load target
    input wire logic [aid_pkg::ADDR_W-1:0] idx_ld_data, // Index load data
    input wire logic [aid_pkg::SEL_W-1:0] rd_sel, // Register read select
    output logic [aid_pkg::DATA_W-1:0] rd_data, // Register read data
    output logic instr_done, // Instruction retired pulse
    output logic mem_wr, // Data memory write pulse
    output logic [aid_pkg::ADDR_W-1:0] mem_addr, // Data memory address
    output logic [aid_pkg::DATA_W-1:0] mem_wdata, // Data memory write data
    output logic flag_z, // Zero flag
    output logic flag_c, // Carry / borrow flag
    output logic flag_v, // Signed overflow flag
    output logic flag_n // Negative flag
);
    import aid_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] rf_r [PHYS_REGS];
    logic [ADDR_W-1:0] idx_r [IDX_COUNT];
    logic [3:0] flags_r;
    logic [DATA_W-1:0] rd_data_r;
    logic done_r;
    logic mem_wr_r;
    logic [ADDR_W-1:0] mem_addr_r;
    logic [DATA_W-1:0] mem_wdata_r;

    // Decode results
    logic is_lim;
    logic is_acc;
    logic is_full;
    logic to_mem;
    logic reg_we;
    logic [SEL_W-1:0] src_sel;
    logic [SEL_W-1:0] dst_sel;
    logic [PHYS_W-1:0] src_phys;
    logic [PHYS_W-1:0] dst_phys;
    logic [PHYS_W-1:0] acc_phys;
    logic [PHYS_W-1:0] ld_phys;
    logic [ADDR_W-1:0] idx_cur;
    logic [ADDR_W-1:0] idx_nxt;
    logic [ADDR_W-1:0] addr_nxt;

    aid_alu_if alu_bus ();

    aid_alu u_alu (
        .alu (alu_bus.core)
    );

    // ---------------------------------------------------------------
    // Register mapping
    // ---------------------------------------------------------------
    // R0-R11 bank, R12-R15 fixed, then alternates, keeping every
    // limited-field register inside the low 28 locations.
    function automatic logic [PHYS_W-1:0] phys_of(
        input logic [SEL_W-1:0] sel,
        input logic bank
    );
        logic [PHYS_W-1:0] wide;
        wide = {1'b0, sel};
        if (sel < BANKED_REGS) begin
            phys_of = bank ? wide + ALT_BANK_BASE : wide; // [RULE9]
        end else if (sel >= LIMITED_REGS) begin
            phys_of = wide + UPPER_OFFSET; // [RULE18]
        end else begin
            phys_of = wide;
        end
    endfunction

    // ---------------------------------------------------------------
    // Instruction decode
    // ---------------------------------------------------------------
    always_comb begin
        is_lim = instr_op inside {add_imm_op, sub_imm_op, and_imm_op,
                                  or_imm_op, xor_imm_op};
        is_acc = instr_op inside {sum_with_acc_op, sum_with_acc_carry_op,
                                  diff_with_acc_op, diff_with_acc_borrow_op,
                                  mask_with_acc_op, merge_with_acc_op,
                                  toggle_with_acc_op};
        is_full = instr_op inside {invert_register_op, shift_left_op,
                                   shift_right_op, rotate_op,
                                   compare_immediate_op, bit_test_op};
        // Limited fields drop the top select bit
        src_sel = is_lim ? {1'b0, source_reg_operand[LSEL_W-1:0]}
                         : source_reg_operand; // [RULE18]
        // Immediate and in-place forms write back to their source
        dst_sel = is_acc ? dest_reg_sel : src_sel; // [RULE2] [RULE10] [RULE13] [RULE8]
        to_mem = is_acc && dst_is_mem; // [RULE3] [RULE12]
        reg_we = instr_valid && alu_bus.keeps_result && !to_mem
                 && (is_lim || is_acc || is_full); // [RULE17]
    end

    assign src_phys = phys_of(src_sel, bank_sel);
    assign dst_phys = phys_of(dst_sel, bank_sel);
    assign acc_phys = phys_of(ACC_REG, bank_sel); // [RULE9]
    assign ld_phys = phys_of(ld_sel, bank_sel);

    // ---------------------------------------------------------------
    // Operand selection into the ALU
    // ---------------------------------------------------------------
    assign alu_bus.op = instr_valid ? instr_op : nop_op;
    assign alu_bus.opa = rf_r[src_phys];
    assign alu_bus.opb = is_acc ? rf_r[acc_phys] : imm_value; // [RULE11] [RULE3] [RULE6]
    assign alu_bus.cin = flags_r[FLAG_C]; // [RULE4] [RULE7]
    assign alu_bus.shamt = imm_value[SHAMT_W-1:0];

    // ---------------------------------------------------------------
    // Index register addressing
    // ---------------------------------------------------------------
    always_comb begin
        idx_cur = idx_r[idx_sel];
        idx_nxt = idx_cur;
        addr_nxt = idx_cur;
        case (idx_mode)
            idx_keep: idx_nxt = idx_cur; // [RULE19]
            idx_post_dec: idx_nxt = idx_cur - IDX_STEP; // [RULE19]
            idx_post_inc: idx_nxt = idx_cur + IDX_STEP; // [RULE19]
            idx_pre_inc: begin
                idx_nxt = idx_cur + IDX_STEP; // [RULE19]
                addr_nxt = idx_nxt;
            end
            default: idx_nxt = idx_cur;
        endcase
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    // Instruction write beats the load port on the same entry.
    for (genvar g = 0; g < PHYS_REGS; g++) begin : g_rf
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                rf_r[g] <= REG_RST;
            end else if (reg_we && dst_phys == PHYS_W'(g)) begin
                rf_r[g] <= alu_bus.res; // [RULE3] [RULE8] [RULE12] [RULE14]
            end else if (ld_valid && ld_phys == PHYS_W'(g)) begin
                rf_r[g] <= ld_data;
            end
        end
    end

    // Index registers clear on reset; auto-update beats a load
    for (genvar i = 0; i < IDX_COUNT; i++) begin : g_idx
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                idx_r[i] <= IDX_RST;
            end else if (instr_valid && to_mem && idx_sel == IDX_SEL_W'(i)) begin
                idx_r[i] <= idx_nxt; // [RULE19]
            end else if (idx_ld_valid && idx_ld_sel == IDX_SEL_W'(i)) begin
                idx_r[i] <= idx_ld_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Condition flags
    // ---------------------------------------------------------------
    for (genvar f = 0; f < 4; f++) begin : g_flag
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                flags_r[f] <= FLAGS_RST[f];
            end else if (instr_valid && alu_bus.flag_upd[f]) begin
                flags_r[f] <= alu_bus.flags[f]; // [RULE20] [RULE15] [RULE16]
            end
        end
    end

    // ---------------------------------------------------------------
    // Data memory write port
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_wr_r <= 1'b0;
        end else begin
            mem_wr_r <= instr_valid && to_mem && alu_bus.keeps_result; // [RULE3] [RULE4]
        end
    end

    // Address and data only move on a write, so they hold afterwards
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_addr_r <= IDX_RST;
            mem_wdata_r <= REG_RST;
        end else if (instr_valid && to_mem) begin
            mem_addr_r <= addr_nxt; // [RULE19]
            mem_wdata_r <= alu_bus.res; // [RULE6] [RULE7] [RULE12]
        end
    end

    // ---------------------------------------------------------------
    // Status and read-back
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= instr_valid;
        end
    end

    // Shows contents before any write landing on the same edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= REG_RST;
        end else begin
            rd_data_r <= rf_r[phys_of(rd_sel, bank_sel)];
        end
    end

    assign rd_data = rd_data_r;
    assign instr_done = done_r;
    assign mem_wr = mem_wr_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign flag_z = flags_r[FLAG_Z];
    assign flag_c = flags_r[FLAG_C];
    assign flag_v = flags_r[FLAG_V];
    assign flag_n = flags_r[FLAG_N];

endmodule

// *** tb/aid_datapath_monitor.sv ***
// Checker for aid_datapath: timing, memory writes and flags at the top ports.
// Assumes aid_pkg is compiled first; attached to the datapath by bind.
`timescale 1ns/1ps
module aid_datapath_monitor (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic instr_valid, // Instruction strobe
    input aid_pkg::aid_op_e instr_op, // Operation
    input wire logic dst_is_mem, // Memory destination
    input wire logic [aid_pkg::IDX_SEL_W-1:0] idx_sel, // Index choice
    input aid_pkg::aid_idx_mode_e idx_mode, // Index update mode
    input wire logic instr_done, // Retire pulse
    input wire logic mem_wr, // Memory write pulse
    input wire logic [aid_pkg::ADDR_W-1:0] mem_addr, // Memory address
    input wire logic [aid_pkg::DATA_W-1:0] mem_wdata, // Memory data
    input wire logic flag_z, // Zero
    input wire logic flag_c, // Carry
    input wire logic flag_v, // Overflow
    input wire logic flag_n // Negative
);
    import aid_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic acc_op;
    logic logic_op;
    logic shift_op;
    logic macc;
    assign acc_op = instr_op inside {sum_with_acc_op, sum_with_acc_carry_op, diff_with_acc_op,
        diff_with_acc_borrow_op, mask_with_acc_op, merge_with_acc_op, toggle_with_acc_op};
    assign logic_op = instr_op inside {and_imm_op, mask_with_acc_op, or_imm_op,
        merge_with_acc_op, xor_imm_op, toggle_with_acc_op, invert_register_op, bit_test_op};
    assign shift_op = instr_op inside {shift_left_op, shift_right_op, rotate_op};
    assign macc = instr_valid && acc_op && dst_is_mem;

    property p_done;
        instr_valid |=> instr_done;
    endproperty
    a_done: assert property (p_done)
        else $error("instr_done missing after instruction");
    property p_idle;
        !instr_valid |=> !instr_done;
    endproperty
    a_idle: assert property (p_idle)
        else $error("instr_done without instruction");
    property p_mem_acc;
        macc |=> mem_wr;
    endproperty
    a_mem_acc: assert property (p_mem_acc)
        else $error("memory write missing");
    property p_no_mem;
        instr_valid && !macc |=> !mem_wr;
    endproperty
    a_no_mem: assert property (p_no_mem)
        else $error("unexpected memory write");
    property p_zn;
        mem_wr |-> (flag_z == (mem_wdata == 8'h00)) && (flag_n == mem_wdata[7]);
    endproperty
    a_zn: assert property (p_zn)
        else $error("Z or N disagrees with written result");
    property p_logic_cv;
        instr_valid && logic_op |=> $stable({flag_c, flag_v});
    endproperty
    a_logic_cv: assert property (p_logic_cv)
        else $error("logic op changed C or V");
    property p_shift_v;
        instr_valid && shift_op |=> $stable(flag_v);
    endproperty
    a_shift_v: assert property (p_shift_v)
        else $error("shift changed V");
    property p_idx;
        macc && idx_mode == idx_post_inc ##1 macc && idx_mode == idx_keep
            && idx_sel == $past(idx_sel) |=> mem_addr == $past(mem_addr) + 16'h0001;
    endproperty
    a_idx: assert property (p_idx)
        else $error("post-increment not seen by next access");
endmodule

bind aid_datapath aid_datapath_monitor mon_u (.sys_clk(sys_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_op(instr_op), .dst_is_mem(dst_is_mem),
    .idx_sel(idx_sel), .idx_mode(idx_mode), .instr_done(instr_done), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .flag_z(flag_z), .flag_c(flag_c),
    .flag_v(flag_v), .flag_n(flag_n));

// *** tb/tb_aid_datapath.sv ***
// Directed self-checking bench for aid_datapath.
// Assumes aid_pkg, the design and its checker are compiled first.
`timescale 1ns/1ps
module tb_aid_datapath;
    import aid_pkg::*;
    logic sys_clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, dmem = 1'h0, bank_sel = 1'h0;
    logic ld_valid = 1'h0, ild_valid = 1'h0, mem_wr, instr_done, fz, fc, fv, fn;
    aid_op_e instr_op = nop_op;
    aid_idx_mode_e imode = idx_keep;
    logic [4:0] src = 5'h00, dst = 5'h00, ld_sel = 5'h00, rd_sel = 5'h00;
    logic [7:0] imm = 8'h00, ld_data = 8'h00, rd_data, mem_wdata;
    logic [15:0] ild_data = 16'h0000, mem_addr;
    logic [23:0] mq[$];
    int n_fail = 0, checks_done = 0, cyc = 0;
    // ---------------------------------------------------------------
    // Scenario table: op, source, immediate, read-back reg, value
    // ---------------------------------------------------------------
    aid_op_e t_op[17] = '{sum_with_acc_op, compare_immediate_op, sum_with_acc_carry_op,
        compare_immediate_op, diff_with_acc_borrow_op, diff_with_acc_op, mask_with_acc_op,
        merge_with_acc_op, toggle_with_acc_op, and_imm_op, or_imm_op, xor_imm_op,
        invert_register_op, shift_left_op, shift_right_op, rotate_op, bit_test_op};
    logic [4:0] t_src[17] = '{5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05,
        5'h03, 5'h03, 5'h13, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14};
    logic [7:0] t_imm[17] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h3C, 8'h0F, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h04, 8'h0C};
    logic [4:0] t_rs[17] = '{5'h07, 5'h05, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07,
        5'h03, 5'h03, 5'h03, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14};
    logic [7:0] t_exp[17] = '{8'h80, 8'h50, 8'h81, 8'h81, 8'h1F, 8'h20, 8'h10, 8'h70, 8'h60,
        8'h30, 8'h3F, 8'hC0, 8'h7E, 8'hFC, 8'h3F, 8'hF3, 8'hF3};

    aid_datapath dut_u (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .source_reg_operand(src), .dest_reg_sel(dst), .imm_value(imm),
        .dst_is_mem(dmem), .idx_sel(2'h1), .idx_mode(imode), .bank_sel(bank_sel),
        .ld_valid(ld_valid), .ld_sel(ld_sel), .ld_data(ld_data), .idx_ld_valid(ild_valid),
        .idx_ld_sel(2'h1), .idx_ld_data(ild_data), .rd_sel(rd_sel), .rd_data(rd_data),
        .instr_done(instr_done), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .flag_z(fz), .flag_c(fc), .flag_v(fv), .flag_n(fn));

    always #2.5 sys_clk = ~sys_clk;
    // Edge-sampled capture avoids racing the design's register updates
    always @(posedge sys_clk) begin
        if (mem_wr === 1'h1) begin
            mq.push_back({mem_addr, mem_wdata});
        end
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    // ---------------------------------------------------------------
    // Drivers and comparisons
    // ---------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic ex(input aid_op_e op, input logic [4:0] s, input logic [4:0] d,
        input logic [7:0] im, input logic m, input aid_idx_mode_e md, input logic hold);
        instr_op <= op;
        src <= s;
        dst <= d;
        imm <= im;
        dmem <= m;
        imode <= md;
        instr_valid <= 1'h1;
        @(posedge sys_clk);
        if (!hold) begin
            instr_valid <= 1'h0;
            @(posedge sys_clk);
        end
    endtask
    task automatic ld(input logic [4:0] s, input logic [7:0] d);
        ld_sel <= s;
        ld_data <= d;
        ld_valid <= 1'h1;
        @(posedge sys_clk);
        ld_valid <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [4:0] s, input logic [7:0] e);
        rd_sel <= s;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) chk(rd_data, e, "register");
        @(posedge sys_clk);
    endtask
    task automatic fchk(input logic [3:0] e);
        @(negedge sys_clk) chk({fn, fv, fc, fz}, e, "flags n v c z");
        @(posedge sys_clk);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_imm_arith;
        ld(5'h02, 8'h7F);
        ex(add_imm_op, 5'h12, 5'h00, 8'h01, 1'h0, idx_keep, 1'h0);
        rdchk(5'h02, 8'h80);
        fchk(4'b1100);
        ex(sub_imm_op, 5'h02, 5'h00, 8'h01, 1'h0, idx_keep, 1'h0);
        rdchk(5'h02, 8'h7F);
        fchk(4'b0100);
        $display("t_imm_arith done");
    endtask
    task automatic t_table;
        ld(5'h00, 8'h30);
        ld(5'h05, 8'h50);
        ld(5'h03, 8'hF0);
        ld(5'h14, 8'h81);
        for (int i = 0; i < 17; i++) begin
            ex(t_op[i], t_src[i], 5'h07, t_imm[i], 1'h0, idx_keep, 1'h0);
            if (t_op[i] == compare_immediate_op) begin
                fchk(4'b0010);
            end
            rdchk(t_rs[i], t_exp[i]);
        end
        fchk(4'b0011);
        rdchk(5'h05, 8'h50);
        rdchk(5'h00, 8'h30);
        $display("t_table done");
    endtask
    task automatic t_mem;
        mq.delete();
        ild_data <= 16'h0040;
        ild_valid <= 1'h1;
        @(posedge sys_clk);
        ild_valid <= 1'h0;
        @(posedge sys_clk);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h1, idx_post_inc, 1'h1);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h1, idx_keep, 1'h0);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h1, idx_pre_inc, 1'h0);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h1, idx_post_dec, 1'h0);
        ex(bit_test_op, 5'h05, 5'h07, 8'hFF, 1'h1, idx_keep, 1'h0);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h1, idx_keep, 1'h0);
        @(negedge sys_clk) chk(24'(mq.size()), 24'h000005, "write count");
        foreach (mq[i]) begin
            chk(mq[i], {16'h0040 + 16'(i < 2 ? i : (i == 4 ? 1 : 2)), 8'h80}, "write");
        end
        @(posedge sys_clk);
        rdchk(5'h07, 8'h60);
        $display("t_mem done");
    endtask
    task automatic t_bank;
        bank_sel <= 1'h1;
        ld(5'h00, 8'h01);
        ld(5'h05, 8'h22);
        ex(sum_with_acc_op, 5'h05, 5'h07, 8'h00, 1'h0, idx_keep, 1'h0);
        rdchk(5'h07, 8'h23);
        bank_sel <= 1'h0;
        rdchk(5'h07, 8'h60);
        rdchk(5'h00, 8'h30);
        $display("t_bank done");
    endtask
    task automatic results;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        t_imm_arith();
        t_table();
        t_mem();
        t_bank();
        results();
    end
endmodule
